// *** pkg/dram_ctrl_pkg.sv ***
/*
 * Constants, states and carrier types of the DRAM
 * controller. Assumes 100 MHz and a 1M x 4 DRAM
 * with a multiplexed address.
 */
// What this block does
// - drive 20-bit address as row half at row strobe, column half at column
// - keep write enable high for reads, low for writes
// - never drive data pins while the device may output
// - page mode: hold row strobe low, pulse column strobe per column
// - refresh all 1,024 rows at least every 16ms
// - self refresh: strobe-reversed refresh then hold row strobe low
// - self-refresh part may refresh one row every 125us
// - leave self refresh with row strobe high at least 110ns
// - distributed strobe-reversed refresh needs no burst after self refresh; here eight follow exit if two slots pass in entry
// - never hold row strobe low longer than 100,000ns; self-refresh entry and self refresh hold it low longer
// - wait 100us then eight refresh cycles; repeat eight when overdue
// - self-refresh entry holds row strobe low at least 100us
package dram_ctrl_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int ROW_W         = 10;
    localparam int ADDR_W        = 20;
    localparam int DQ_W          = 4;
    localparam int CNT_W         = 16;
    localparam int SYNC_STAGES   = 2;

    // timing figures in their own units
    localparam int RCD_NS        = 20;
    localparam int RAS_NS        = 60;
    localparam int RP_NS         = 40;
    localparam int RC_NS         = 110;
    localparam int CAC_NS        = 15;
    localparam int ROW_ACCESS_NS = 60;
    localparam int CAS_NS        = 15;
    localparam int CP_NS         = 10;
    localparam int CSR_NS        = 10;
    localparam int SR_EXIT_NS    = 110;
    localparam int RAS_MAX_NS    = 100000;
    localparam int POWERUP_US    = 100;
    localparam int SR_ENTRY_US   = 100;
    localparam int REF_PERIOD_NS = 16000000;
    localparam int ROW_COUNT     = 1024;
    localparam int WAKE_CYCLES   = 8;

    // least times round up to whole cycles
    localparam int RCD_C  = (RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAS_C  = (RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAC_C  = (CAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAC_C  = (ROW_ACCESS_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
    localparam int PRE_NS = (RP_NS > RC_NS - RAS_NS) ? RP_NS : RC_NS - RAS_NS;
    localparam int RD_C   = ((CAC_C > RAC_C - RCD_C) ? CAC_C : RAC_C - RCD_C)
                            + SYNC_STAGES + 1;

    localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(RCD_C);
    localparam logic [CNT_W-1:0] RAS_CYC = CNT_W'(RAS_C);
    localparam logic [CNT_W-1:0] PRE_CYC =
        CNT_W'((PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RD_CAS_CYC = CNT_W'(RD_C);
    localparam logic [CNT_W-1:0] WR_CAS_CYC =
        CNT_W'((CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CP_CYC =
        CNT_W'((CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CSR_CYC =
        CNT_W'((CSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SR_EXIT_CYC =
        CNT_W'((SR_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // a longest time rounds down
    localparam logic [CNT_W-1:0] REF_INT_CYC =
        CNT_W'(REF_PERIOD_NS / ROW_COUNT / CLK_PERIOD_NS);
    localparam logic [3:0] WAKE_CNT = 4'(WAKE_CYCLES);

    typedef enum logic [9:0] {
        ST_INIT    = 10'h001,
        ST_IDLE    = 10'h002,
        ST_RAS     = 10'h004,
        ST_CAS     = 10'h008,
        ST_OPEN    = 10'h010,
        ST_PRECH   = 10'h020,
        ST_CBR_CAS = 10'h040,
        ST_CBR_RAS = 10'h080,
        ST_SELF    = 10'h100,
        ST_SR_EXIT = 10'h200
    } ctrl_state_e;

    // strobes and multiplexed address going to the memory
    typedef struct packed {
        logic [ROW_W-1:0] muxed_address_pins;
        logic             ras_n;
        logic             cas_n;
        logic             we_n;
        logic             oe_n;
    } dram_pins_s;

    // one user request
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0]   wdata;
    } mem_req_s;

    localparam dram_pins_s PINS_IDLE = '{
        muxed_address_pins: '0, ras_n: 1'b1, cas_n: 1'b1,
        we_n: 1'b1, oe_n: 1'b1};

endpackage

// *** design/dq_sync.sv ***
/*
 * Two-flop synchroniser for the shared data pins read back from the
 * memory. Assumes the pins change with no relation to sys_clk.
 */
`timescale 1ns/10ps
module dq_sync #(
    parameter int W = 4
) (
    input  wire logic         sys_clk, // system clock
    input  wire logic         rst_n,   // async reset, active low
    input  wire logic [W-1:0] d_in,    // asynchronous input
    output logic      [W-1:0] d_out    // synchronised copy
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            d_out  <= '0;
        end else begin
            meta_r <= d_in;
            d_out  <= meta_r;
        end
    end
endmodule

// *** design/refresh_sched.sv ***
/*
 * Asks for one refresh per interval,
 * flags an overrun at two owed slots.
 * Assumes each started refresh is acked.
 */
`timescale 1ns/10ps
module refresh_sched
    import dram_ctrl_pkg::*;
(
    input  wire logic sys_clk,  // system clock
    input  wire logic rst_n,    // async reset, active low
    input  wire logic clr,      // restart timing (self refresh)
    input  wire logic ack,      // one refresh started
    output logic      due,      // refresh owed
    output logic      overdue   // pulse: interval exceeded
);
    logic [CNT_W-1:0] tick_r;
    logic [1:0]       pend_r;
    logic             tick;

    assign tick = (tick_r == '0);

    // interval timer, one slot per row keeps all rows inside the period
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= REF_INT_CYC - 1'b1;
        end else if (clr || tick) begin
            tick_r <= REF_INT_CYC - 1'b1;
        end else begin
            tick_r <= tick_r - 1'b1;
        end
    end

    // owed refreshes; a new slot and a same-cycle ack cancel out
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r  <= 2'h0;
            overdue <= 1'b0;
        end else begin
            overdue <= 1'b0;
            if (clr) begin
                pend_r <= 2'h0;
            end else if (tick && !ack) begin
                if (pend_r == 2'h1) begin
                    overdue <= 1'b1;
                end
                if (pend_r != 2'h2) begin
                    pend_r <= pend_r + 2'h1;
                end
            end else if (ack && !tick && pend_r != 2'h0) begin
                pend_r <= pend_r - 2'h1;
            end
        end
    end

    assign due = (pend_r != 2'h0);
endmodule

// *** design/dram_page_ctrl.sv ***
/*
 * Host-side controller for a 1M x 4 page-mode DRAM.
 * Keeps rows open for hits, refreshes by
 * strobe-reversed cycles, can park in self refresh.
 * Assumes a 100 MHz clock, a self-refresh part
 * and same-clock requests.
 */
`timescale 1ns/10ps
module dram_page_ctrl #(
    parameter int unsigned POWERUP_CYC =
        dram_ctrl_pkg::POWERUP_US * 1000 / dram_ctrl_pkg::CLK_PERIOD_NS,
    parameter int unsigned SR_ENTRY_CYC =
        dram_ctrl_pkg::SR_ENTRY_US * 1000 / dram_ctrl_pkg::CLK_PERIOD_NS,
    parameter int unsigned RAS_MAX_CYC =
        dram_ctrl_pkg::RAS_MAX_NS / dram_ctrl_pkg::CLK_PERIOD_NS
) (
    input  wire logic                            sys_clk,    // clock
    input  wire logic                            rst_n,      // reset
    input  wire logic                            req_valid,  // request
    input  wire dram_ctrl_pkg::mem_req_s         req,        // payload
    output logic                                 req_ready,  // can take
    output logic                                 rsp_valid,  // read done
    output logic [dram_ctrl_pkg::DQ_W-1:0]       rsp_rdata,  // read word
    input  wire logic                            sr_req,     // self ref
    output logic                                 sr_active,  // in self
    output logic                                 init_done,  // ready
    output dram_ctrl_pkg::dram_pins_s            pins,       // strobes
    input  wire logic [dram_ctrl_pkg::DQ_W-1:0]  dq_in,      // pin level
    output logic [dram_ctrl_pkg::DQ_W-1:0]       dq_out,     // pin drive
    output logic                                 dq_oe_n     // 0 drives
);
    import dram_ctrl_pkg::*;

    localparam logic [CNT_W-1:0] PAGE_LIMIT =
        CNT_W'(RAS_MAX_CYC - 32'(RD_CAS_CYC) - 32'(CP_CYC) - 3);

    ctrl_state_e       state_r;
    ctrl_state_e       state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [CNT_W-1:0]  ras_time_r;
    mem_req_s          req_r;
    logic              pend_r;
    logic              pend_nxt;
    logic              self_r;
    logic              self_nxt;
    logic [3:0]        wake_r;
    logic [ROW_W-1:0]  open_row_r;
    logic [DQ_W-1:0]   dq_s;
    logic              ref_due;
    logic              ref_overdue;
    logic              ref_ack;
    logic              accept;
    logic              need_close;
    logic              same_row;
    dram_pins_s        pins_nxt;
    logic              dq_oe_n_nxt;

    dq_sync #(
        .W       (DQ_W)
    ) u_dq_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d_in    (dq_in),
        .d_out   (dq_s)
    );

    refresh_sched u_refresh_sched (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clr     (state_r == ST_SELF),
        .ack     (ref_ack),
        .due     (ref_due),
        .overdue (ref_overdue)
    );

    assign accept   = req_valid && req_ready;
    assign same_row = (req_r.addr[ADDR_W-1:ROW_W] == open_row_r);
    assign ref_ack  = (state_r == ST_CBR_CAS) && (cnt_r == '0);
    // reasons to give up the open row; the page timer bounds row-low time
    assign need_close = ref_due || (wake_r != 4'h0) || sr_req
                        || (ras_time_r >= PAGE_LIMIT);

    // sequencing of strobes; each state but idle, open and self lasts cnt+1 cycles
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r != '0) ? cnt_r - 1'b1 : '0;
        pend_nxt  = pend_r || accept;
        self_nxt  = self_r;
        unique case (state_r)
            ST_INIT: begin
                if (cnt_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (wake_r != 4'h0 || ref_due || sr_req) begin
                    // refresh first: a queued access waits out every owed or wake refresh and any self refresh
                    state_nxt = ST_CBR_CAS;
                    cnt_nxt   = CSR_CYC - 1'b1;
                    self_nxt  = sr_req && wake_r == 4'h0 && !ref_due;
                end else if (pend_r) begin
                    state_nxt = ST_RAS;
                    cnt_nxt   = RCD_CYC - 1'b1;
                end
            end
            ST_RAS: begin
                if (cnt_r == '0) begin
                    state_nxt = ST_CAS;
                    pend_nxt  = 1'b0;
                    cnt_nxt   = (req_r.write ? WR_CAS_CYC : RD_CAS_CYC)
                                - 1'b1;
                end
            end
            ST_CAS: begin
                if (cnt_r == '0) begin
                    state_nxt = ST_OPEN;
                    cnt_nxt   = CP_CYC - 1'b1;
                end
            end
            ST_OPEN: begin
                if (cnt_r != '0) begin
                    state_nxt = ST_OPEN;
                end else if (need_close || (pend_r && !same_row)) begin
                    if (ras_time_r >= RAS_CYC) begin
                        state_nxt = ST_PRECH;
                        cnt_nxt   = PRE_CYC - 1'b1;
                    end
                end else if (pend_r && req_r.write && pins.we_n) begin
                    state_nxt = ST_OPEN;
                end else if (pend_r) begin
                    state_nxt = ST_CAS;
                    pend_nxt  = 1'b0;
                    cnt_nxt   = (req_r.write ? WR_CAS_CYC : RD_CAS_CYC)
                                - 1'b1;
                end
            end
            ST_PRECH: begin
                if (cnt_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_CBR_CAS: begin
                if (cnt_r == '0) begin
                    state_nxt = ST_CBR_RAS;
                    cnt_nxt   = self_r ? CNT_W'(SR_ENTRY_CYC - 1)
                                       : RAS_CYC - 1'b1;
                end
            end
            ST_CBR_RAS: begin
                if (cnt_r == '0) begin
                    if (self_r) begin
                        state_nxt = ST_SELF;
                    end else begin
                        state_nxt = ST_PRECH;
                        cnt_nxt   = PRE_CYC - 1'b1;
                    end
                end
            end
            ST_SELF: begin
                if (!sr_req) begin
                    state_nxt = ST_SR_EXIT;
                    cnt_nxt   = SR_EXIT_CYC - 1'b1;
                    self_nxt  = 1'b0;
                end
            end
            ST_SR_EXIT: begin
                // distributed refresh resumes at once unless two slots passed during entry; then eight wake refreshes come first
                if (cnt_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_PRECH;
                cnt_nxt   = PRE_CYC - 1'b1;
            end
        endcase
    end

    // pin levels decoded from the coming state so they leave flops
    always_comb begin
        pins_nxt    = PINS_IDLE;
        dq_oe_n_nxt = 1'b1;
        unique case (state_nxt)
            ST_RAS: begin
                pins_nxt.ras_n = 1'b0;
                pins_nxt.muxed_address_pins =
                    req_r.addr[ADDR_W-1:ROW_W];
                pins_nxt.we_n  = !req_r.write;
                pins_nxt.oe_n  = req_r.write;
                dq_oe_n_nxt    = !req_r.write;
            end
            ST_CAS: begin
                pins_nxt.ras_n = 1'b0;
                pins_nxt.cas_n = 1'b0;
                pins_nxt.muxed_address_pins =
                    req_r.addr[ROW_W-1:0];
                // write enable is low no later than the column fall
                pins_nxt.we_n  = !req_r.write;
                pins_nxt.oe_n  = req_r.write;
                dq_oe_n_nxt    = !req_r.write;
            end
            ST_OPEN: begin
                pins_nxt.ras_n = 1'b0;
                pins_nxt.muxed_address_pins = req_r.addr[ROW_W-1:0];
                // a page write lowers write enable a cycle early
                pins_nxt.we_n  = !(pend_r && req_r.write && same_row);
                dq_oe_n_nxt    = pins_nxt.we_n;
            end
            ST_CBR_CAS: begin
                pins_nxt.cas_n = 1'b0;
            end
            ST_CBR_RAS, ST_SELF: begin
                pins_nxt.ras_n = 1'b0;
                pins_nxt.cas_n = 1'b0;
            end
            default: begin
                pins_nxt = PINS_IDLE;
            end
        endcase
    end

    // state, timer and the queued request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_INIT;
            cnt_r   <= CNT_W'(POWERUP_CYC - 1);
            pend_r  <= 1'b0;
            self_r  <= 1'b0;
            req_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            pend_r  <= pend_nxt;
            self_r  <= self_nxt;
            if (accept) begin
                req_r <= req;
            end
        end
    end

    // row bookkeeping for page hits and the row-low time limit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ras_time_r <= '0;
            open_row_r <= '0;
        end else if (state_nxt == ST_RAS && state_r != ST_RAS) begin
            ras_time_r <= '0;
            open_row_r <= req_r.addr[ADDR_W-1:ROW_W];
        end else if (ras_time_r != '1) begin
            ras_time_r <= ras_time_r + 1'b1;
        end
    end

    // wake-up refresh count: eight after power-up and after any overrun
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_r    <= WAKE_CNT;
            init_done <= 1'b0;
        end else begin
            if (ref_overdue) begin
                wake_r <= WAKE_CNT;
            end else if (ref_ack && wake_r != 4'h0) begin
                wake_r <= wake_r - 4'h1;
            end
            if (state_r != ST_INIT && wake_r == 4'h0) begin
                init_done <= 1'b1;
            end
        end
    end

    // registered pins and user-side outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins      <= PINS_IDLE;
            dq_oe_n   <= 1'b1;
            dq_out    <= '0;
            req_ready <= 1'b0;
            sr_active <= 1'b0;
        end else begin
            pins      <= pins_nxt;
            dq_oe_n   <= dq_oe_n_nxt;
            dq_out    <= req_r.wdata;
            req_ready <= !pend_nxt && init_done
                         && (state_nxt == ST_IDLE || state_nxt == ST_OPEN);
            sr_active <= (state_nxt == ST_SELF);
        end
    end

    // read data is taken from the synchronised pins at the column's end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_r == ST_CAS && cnt_r == '0 && !req_r.write) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= dq_s;
            end
        end
    end
endmodule

// *** verif/dram_page_ctrl_props.sv ***
/*
 * Port checker for the DRAM controller.
 * Assumes binding to each controller.
 */
`timescale 1ns/10ps
module dram_page_ctrl_props
    import dram_ctrl_pkg::*;
#(
    parameter int unsigned POWERUP_CYC  = 20,
    parameter int unsigned SR_ENTRY_CYC = 20,
    parameter int unsigned RAS_MAX_CYC  = 40
) (
    input wire logic                       sys_clk,   // clock
    input wire logic                       rst_n,     // reset
    input wire logic                       req_valid, // request
    input wire dram_ctrl_pkg::mem_req_s    req,       // payload
    input wire logic                       req_ready, // taken
    input wire logic                       rsp_valid, // read done
    input wire logic [dram_ctrl_pkg::DQ_W-1:0] rsp_rdata, // read word
    input wire logic                       sr_req,    // self ref ask
    input wire logic                       sr_active, // parked
    input wire logic                       init_done, // ready
    input wire dram_ctrl_pkg::dram_pins_s  pins,      // strobes
    input wire logic [dram_ctrl_pkg::DQ_W-1:0] dq_in,  // pin level
    input wire logic [dram_ctrl_pkg::DQ_W-1:0] dq_out, // pin drive
    input wire logic                       dq_oe_n    // 0 drives
);
    int unsigned low_cnt; // earlier consecutive row-low cycles
    logic        cbr_r;   // row low period began column first

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // row-low run length
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 0;
        else if (pins.ras_n) low_cnt <= 0;
        else low_cnt <= low_cnt + 1;
    end

    // refresh start marker
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cbr_r <= 1'b0;
        else if (pins.ras_n) cbr_r <= !pins.cas_n;
    end

    property p_drive_write;
        !dq_oe_n |-> !pins.we_n && pins.oe_n;
    endproperty
    a_drive_write: assert property (p_drive_write)
        else $error("drive outside write");
    property p_oe_read;
        !pins.oe_n |-> pins.we_n && dq_oe_n;
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("oe during write");
    property p_cbr;
        $fell(pins.ras_n) && !pins.cas_n |-> pins.we_n && dq_oe_n;
    endproperty
    a_cbr: assert property (p_cbr)
        else $error("refresh without we high");
    property p_early;
        $fell(pins.cas_n) && !pins.ras_n && !pins.we_n
            |-> $past(!pins.we_n);
    endproperty
    a_early: assert property (p_early)
        else $error("we not before column");
    property p_col_hold;
        !pins.cas_n && $past(!pins.cas_n) && !pins.ras_n && !cbr_r
            |-> $stable(pins.muxed_address_pins);
    endproperty
    a_col_hold: assert property (p_col_hold)
        else $error("column address moved");
    property p_rd_len;
        rsp_valid |-> !$past(pins.cas_n) && !$past(pins.cas_n, 7)
            && $past(pins.cas_n, 8) && $past(pins.we_n);
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("read column time");
    property p_ras_max;
        !pins.ras_n && !cbr_r |-> low_cnt < RAS_MAX_CYC;
    endproperty
    a_ras_max: assert property (p_ras_max)
        else $error("row low too long");
    property p_prech;
        $rose(pins.ras_n) |-> pins.ras_n [*5];
    endproperty
    a_prech: assert property (p_prech)
        else $error("short precharge");
    property p_sr_exit;
        $rose(pins.ras_n) && $past(cbr_r) && $past(low_cnt) > 8
            |-> pins.ras_n [*8];
    endproperty
    a_sr_exit: assert property (p_sr_exit)
        else $error("short self-refresh exit");
    property p_sr_entry;
        $rose(sr_active) |-> cbr_r && !pins.ras_n
            && low_cnt >= SR_ENTRY_CYC - 1;
    endproperty
    a_sr_entry: assert property (p_sr_entry)
        else $error("early self refresh");
    property p_ready;
        req_ready |-> init_done;
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready before wake-up");

    c_read: cover property (rsp_valid);
    c_write: cover property (!dq_oe_n);
    c_self: cover property ($rose(sr_active));
    c_cbr: cover property ($fell(pins.ras_n) && !pins.cas_n);
endmodule

bind dram_page_ctrl dram_page_ctrl_props #(
    .POWERUP_CYC(POWERUP_CYC), .SR_ENTRY_CYC(SR_ENTRY_CYC),
    .RAS_MAX_CYC(RAS_MAX_CYC)
) i_dram_page_ctrl_props (
    .sys_clk, .rst_n, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp_rdata, .sr_req, .sr_active, .init_done, .pins, .dq_in,
    .dq_out, .dq_oe_n
);

// *** verif/dram_model.sv ***
/*
 * Behavioural 1M x 4 page-mode DRAM driven by strobe edges.
 * Assumes the bench resolves the shared pins from q, d and dq_oe_n.
 */
`timescale 1ns/10ps
module dram_model #(
    parameter int ACC_NS = 45
) (
    input  wire logic [9:0] addr,  // multiplexed address
    input  wire logic       ras_n, // row strobe
    input  wire logic       cas_n, // column strobe
    input  wire logic       we_n,  // write enable
    input  wire logic       oe_n,  // output enable
    input  wire logic [3:0] d,     // controller data
    output logic      [3:0] q,     // pin value seen by controller
    output logic            q_en   // model drives pins
);
    logic [3:0] mem [logic [19:0]];
    logic [9:0] row_r = 10'h000;
    logic [9:0] col_r = 10'h000;
    logic [9:0] rcnt  = 10'h000;
    logic       valid = 1'b0;
    logic [3:0] dout  = 4'h0;

    // row fall: row latch or counter bump
    always @(negedge ras_n) begin
        if (!cas_n) rcnt = rcnt + 10'h001;
        else row_r = addr;
    end

    // column fall: write or read
    always @(negedge cas_n) begin
        if (!ras_n) begin
            col_r = addr;
            if (!we_n) mem[{row_r, col_r}] = d;
            else begin
                dout = mem.exists({row_r, col_r}) ? mem[{row_r, col_r}]
                                                  : 4'h0;
                #ACC_NS valid = !cas_n;
            end
        end
    end

    // late write at write-enable fall
    always @(negedge we_n) begin
        if (!ras_n && !cas_n) mem[{row_r, col_r}] = d;
    end

    // released pins read back inverted
    always @(posedge cas_n) valid = 1'b0;
    assign q_en = valid && !cas_n && !oe_n;
    assign q    = q_en ? dout : ~dout;
endmodule

// *** verif/dram_page_ctrl_tb.sv ***
/*
 * Self-checking bench for the page-mode DRAM controller.
 * Assumes the behavioural dram_model and the bound port checker.
 */
`timescale 1ns/10ps
module dram_page_ctrl_tb;
    import dram_ctrl_pkg::*;
    logic                sys_clk, rst_n, req_valid, req_ready, rsp_valid;
    logic                sr_req, sr_active, init_done, dq_oe_n, m_en;
    mem_req_s            req;
    dram_pins_s          pins;
    logic [DQ_W-1:0]     rsp_rdata, dq_in, dq_out, m_q;
    logic [DQ_W-1:0]     shadow [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0]   a;
    logic [ADDR_W-1:0]   corner [4] = '{20'h00000, 20'hfffff,
                                        20'h55400, 20'h557ff};
    int                  mismatches, num_checks, wake, clash, i;

    dram_page_ctrl #(.POWERUP_CYC(20), .SR_ENTRY_CYC(20),
                     .RAS_MAX_CYC(40)) i_dram_page_ctrl (
        .sys_clk, .rst_n, .req_valid, .req, .req_ready, .rsp_valid,
        .rsp_rdata, .sr_req, .sr_active, .init_done, .pins, .dq_in,
        .dq_out, .dq_oe_n);
    dram_model i_dram_model (
        .addr(pins.muxed_address_pins), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .oe_n(pins.oe_n),
        .d(dq_out), .q(m_q), .q_en(m_en));

    // resolve shared pins
    assign dq_in = dq_oe_n ? m_q : dq_out;

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // count contention and wake refreshes
    always @(posedge sys_clk) if (m_en && !dq_oe_n) clash++;
    always @(negedge pins.ras_n) if (!pins.cas_n && !init_done) wake++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [DQ_W-1:0] exp_of(logic [ADDR_W-1:0] k);
        return shadow.exists(k) ? shadow[k] : 4'h0;
    endfunction

    // one request; reads await the answer
    task automatic do_req(input logic w, input logic [ADDR_W-1:0] ad,
                          input logic [DQ_W-1:0] wd);
        int n;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{write: w, addr: ad, wdata: wd};
        n = 0;
        do @(posedge sys_clk); while (req_ready !== 1'b1 && ++n < 300);
        req_valid <= 1'b0;
        check(32'(req_ready), 1, "taken");
        if (w) shadow[ad] = wd;
        else begin
            n = 0;
            do @(posedge sys_clk); while (rsp_valid !== 1'b1 && ++n < 100);
            check(32'(rsp_rdata), 32'(exp_of(ad)), "rdata");
        end
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        sr_req = 1'b0;
        void'($urandom(32'h8f14));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 2000 && init_done !== 1'b1; i++) @(posedge sys_clk);
        check(32'(init_done), 1, "wake");
        check(wake, 8, "wakes");
        foreach (corner[j]) do_req(1'b1, corner[j], 4'(j) ^ 4'hc);
        foreach (corner[j]) do_req(1'b0, corner[j], 4'h0);
        // random page hits and misses
        for (i = 0; i < 300; i++) begin
            a = {10'($urandom_range(3)), 7'h00, 3'($urandom)};
            if (!shadow.exists(a) || $urandom_range(1) == 0)
                do_req(1'b1, a, 4'($urandom));
            else do_req(1'b0, a, 4'h0);
            repeat ($urandom_range(30)) @(posedge sys_clk);
        end
        sr_req <= 1'b1;
        for (i = 0; i < 500 && sr_active !== 1'b1; i++) @(posedge sys_clk);
        check(32'(sr_active), 1, "sr in");
        check(32'({pins.ras_n, pins.cas_n}), 0, "parked");
        repeat (50) @(posedge sys_clk);
        sr_req <= 1'b0;
        for (i = 0; i < 100 && sr_active !== 1'b0; i++) @(posedge sys_clk);
        check(32'(sr_active), 0, "sr out");
        foreach (shadow[k]) do_req(1'b0, k, 4'h0);
        check(clash, 0, "clash");
        final_report();
    end

    // watchdog
    initial begin
        #1000000;
        mismatches++;
        final_report();
    end
endmodule
